/* cts_pkg.sv */
// package: constants, register map and carrier types of the trap syndrome unit
package cts_pkg;

  // ************************************************************
  // register map (byte offsets on the 32-bit register bus)
  // ************************************************************
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_HYP_CTRL = 8'h00;
  localparam logic [7:0] OFS_KMON_CTRL = 8'h04;
  localparam logic [7:0] OFS_SYNDROME = 8'h08;
  localparam logic [7:0] OFS_TRAP_STAT = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] HYP_CTRL_RST = 16'h0000;
  localparam logic [15:0] KMON_CTRL_RST = 16'h0000;

  // hypervisor trap control bits
  localparam int HB_TLB = 0;
  localparam int HB_CACHE = 1;
  localparam int HB_AUXCTL = 2;
  localparam int HB_ID = 3;
  localparam int HB_VM_READ = 4;
  localparam int HB_VM_WRITE = 5;
  localparam int HB_SYSREG = 6;
  localparam int HB_COMMS = 7;
  localparam int HB_PD_DBG = 8;
  localparam int HB_DBG = 9;
  localparam int HB_TRACE = 10;
  localparam int HB_ID0 = 11;
  localparam int HB_ID3 = 12;
  localparam int HB_DBG_ROM = 13;
  localparam int HB_FGT = 14;
  // kernel and monitor trap control bits
  localparam int KB_USER_TIMER_EN = 0;
  localparam int KB_USER_PERF_EN = 1;
  localparam int KB_USER_ACT_EN = 2;
  localparam int KB_COMMS = 3;
  localparam int KB_TRACE = 4;
  localparam int KB_WIDE_LS = 5;
  localparam int MB_COPROC_ACC = 8;
  localparam int MB_COMMS = 9;
  localparam int MB_PD_DBG = 10;
  localparam int MB_DBG = 11;
  localparam int MB_TRACE = 12;

  // ************************************************************
  // syndrome encoding
  // ************************************************************
  localparam logic [5:0] EC_MOVE_SYS = 6'h03;
  localparam logic [5:0] EC_MOVE_DBG = 6'h05;
  localparam logic [5:0] EC_FLOAT_ID = 6'h08;
  localparam logic [5:0] EC_PAIR_SYS = 6'h04;
  localparam logic [5:0] EC_PAIR_DBG = 6'h0C;
  localparam logic [3:0] CP_SYS = 4'hF;
  localparam logic [3:0] CP_DBG = 4'hE;
  localparam logic [3:0] CODE_A_ALWAYS = 4'hE;
  localparam logic [3:0] REG_PC = 4'hF;
  localparam logic [4:0] REG_ZR = 5'h1F;
  localparam logic [2:0] FLOAT_FIRST_OPCODE_FIELD = 3'h7;
  localparam int ISS_CV = 24;
  localparam int ISS_CODE_A = 20;
  localparam int ISS_OPC2 = 17;
  localparam int ISS_FIRST_OPCODE_FIELD = 14;
  localparam int ISS_CRN = 10;
  localparam int ISS_PAIR_FIRST_OPCODE_FIELD = 16;
  localparam int ISS_PAIR_RSV = 15;
  localparam int ISS_RT2 = 10;
  localparam int ISS_RT = 5;
  localparam int ISS_CRM = 1;
  localparam int ISS_DIR = 0;
  localparam logic [1:0] LVL_USER = 2'h0;
  localparam logic [1:0] LVL_KERNEL = 2'h1;
  localparam logic [1:0] LVL_HYP = 2'h2;
  localparam logic [1:0] LVL_MON = 2'h3;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef enum logic [1:0] {
    CTS_MOVE_ONE = 2'b00, CTS_MOVE_PAIR = 2'b01, CTS_FLOAT_READ = 2'b10, CTS_WIDE_LS = 2'b11
  } cts_kind_t;

  typedef enum logic [4:0] {
    GRP_PLAIN = 5'b00000, GRP_TIMER = 5'b00001, GRP_PERF = 5'b00010, GRP_ACTMON = 5'b00011,
    GRP_VMEM = 5'b00100, GRP_TLB = 5'b00101, GRP_CACHE = 5'b00110, GRP_AUXCTL = 5'b00111,
    GRP_ID = 5'b01000, GRP_SYSREG = 5'b01001, GRP_COPROC_ACC = 5'b01010,
    GRP_HYP_TRAP_REG = 5'b01011, GRP_COMMS_CHAN = 5'b01100, GRP_ID0 = 5'b01101,
    GRP_ID3 = 5'b01110, GRP_PD_DBG = 5'b01111, GRP_DBG = 5'b10000, GRP_TRACE = 5'b10001,
    GRP_DBG_ROM = 5'b10010, GRP_FGT_SEL = 5'b10011
  } cts_group_t;

  typedef enum logic [1:0] {
    VAR_STORE_STATUS = 2'b00, VAR_STORE_ACCUM = 2'b01, VAR_LOAD_STORE = 2'b10
  } cts_variant_t;

  typedef struct packed {
    logic valid;
    cts_kind_t kind;
    cts_group_t group;
    logic is_read;
    logic [3:0] coproc;
    logic [1:0] level;
    logic from_64;
    logic mixed_len;
    logic conditional;
    logic [3:0] code_a;
    logic [3:0] first_opcode_field;
    logic [2:0] opc2;
    logic [3:0] crn;
    logic [3:0] coproc_minor_reg;
    logic [3:0] rt;
    logic [3:0] rt2;
    cts_variant_t variant;
  } cts_req_t;

  typedef struct packed {
    logic [15:0] hyp_ctrl;
    logic [15:0] kmon_ctrl;
    logic aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic resp_valid;
    logic resp_trap;
    logic [1:0] resp_level;
    logic [5:0] ec;
    logic [24:0] syndrome_specific_field;
    logic [15:0] trap_count;
  } cts_state_t;

endpackage : cts_pkg

/* cts_trap_syndrome.sv */
// module: trap routing and syndrome capture for coprocessor moves and wide accesses
`timescale 1ns/1ns

// How it works
// - direction bit 0 is one for reads, zero for writes to system registers
// - single moves to coprocessor 15 report class 0x03
// - single moves to coprocessor 14 report class 0x05
// - float reads of ID groups 0 and 3 trap to hypervisor, class 0x08
// - cleared user enables trap user timer, perf, activity accesses upward
// - hypervisor controls trap TLB, cache, auxiliary and ID accesses
// - monitor control traps access-control and hypervisor trap register accesses
// - comms channel accesses trap to kernel, plus hypervisor/monitor with fine traps
// - powerdown and other debug registers trap per level's own control
// - trace accesses via coprocessor 14 trap per kernel, hypervisor, monitor control
// - only reads of ID group 0 register trap under group 0 control
// - wide access syndrome is a distinct code per variant
// - condition valid is one for 64-bit and fixed-length sources
// - condition field is 0xE or the conditional instruction's code, and zero when condition valid is zero
// - mixed-length choice of condition reporting fixed by parameter
// - passing conditional may report 0xE or its own code, by parameter
// - pair transfers copy first opcode into bits 19:16, bit 15 zero
// - syndrome contents read as zero from reset until the first trap
// - fine-grained controls trap selected user single moves to hypervisor
// - virtual memory and per-register controls trap kernel accesses to hypervisor
// - debug ROM address accesses trap to hypervisor under its control
// - single moves copy minor register to bits 4:1, register to 9:5
// - register specifier 15 is reported as 0x1F
// - pair transfers report second register in bits 14:10
module cts_trap_syndrome
  import cts_pkg::*;
#(
  parameter bit FGT_IMPL = 1'b1,
  parameter bit MIXED_CV = 1'b1,
  parameter bit PASS_AS_UNCOND = 1'b0,
  parameter logic [5:0] EC_WIDE_LS = 6'h0A
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cts_req_t req,
  output logic resp_valid,
  output logic resp_trap,
  output logic [1:0] resp_level,
  output logic [5:0] resp_class,
  output logic [24:0] resp_syndrome
);
  cts_state_t state_reg;
  cts_state_t state_next;

  // ************************************************************
  // trap routing
  // ************************************************************
  logic [15:0] hc, kc;
  logic cp32, from_user, below_hyp, below_mon, fgt_on;
  logic kern_hit, hyp_hit, mon_hit;
  assign hc = state_reg.hyp_ctrl;
  assign kc = state_reg.kmon_ctrl;
  assign fgt_on = FGT_IMPL;
  // only 32-bit coprocessor-style transfers go through these controls
  assign cp32 = !req.from_64 && (req.kind != CTS_WIDE_LS);
  assign from_user = req.level == LVL_USER;
  assign below_hyp = req.level <= LVL_KERNEL;
  assign below_mon = req.level <= LVL_HYP;

  always_comb begin
    kern_hit = 1'b0;
    if (cp32 && from_user) begin
      unique case (req.group)
        GRP_TIMER: kern_hit = !kc[KB_USER_TIMER_EN];
        GRP_PERF: kern_hit = !kc[KB_USER_PERF_EN];
        GRP_ACTMON: kern_hit = !kc[KB_USER_ACT_EN];
        GRP_COMMS_CHAN: kern_hit = kc[KB_COMMS];
        GRP_TRACE: kern_hit = kc[KB_TRACE] && req.coproc == CP_DBG;
        default: kern_hit = 1'b0;
      endcase
    end
    if (req.kind == CTS_WIDE_LS && from_user) begin
      kern_hit = kc[KB_WIDE_LS];
    end
  end

  always_comb begin
    hyp_hit = 1'b0;
    if (cp32 && below_hyp) begin
      unique case (req.group)
        GRP_TLB: hyp_hit = hc[HB_TLB] && !from_user;
        GRP_CACHE: hyp_hit = hc[HB_CACHE];
        GRP_AUXCTL: hyp_hit = hc[HB_AUXCTL] && !from_user;
        GRP_ID: hyp_hit = hc[HB_ID];
        GRP_VMEM: hyp_hit = !from_user &&
          (req.is_read ? hc[HB_VM_READ] : hc[HB_VM_WRITE]);
        GRP_SYSREG: hyp_hit = hc[HB_SYSREG];
        GRP_COMMS_CHAN: hyp_hit = fgt_on && hc[HB_COMMS];
        GRP_PD_DBG: hyp_hit = hc[HB_PD_DBG];
        GRP_DBG: hyp_hit = hc[HB_DBG];
        GRP_TRACE: hyp_hit = hc[HB_TRACE] && req.coproc == CP_DBG;
        GRP_ID0: hyp_hit = hc[HB_ID0] && (req.kind == CTS_FLOAT_READ ||
          req.is_read);
        GRP_ID3: hyp_hit = hc[HB_ID3] && req.kind == CTS_FLOAT_READ;
        GRP_DBG_ROM: hyp_hit = hc[HB_DBG_ROM];
        GRP_FGT_SEL: hyp_hit = fgt_on && hc[HB_FGT] && from_user &&
          req.kind == CTS_MOVE_ONE;
        default: hyp_hit = 1'b0;
      endcase
    end
  end

  always_comb begin
    mon_hit = 1'b0;
    if (cp32 && below_mon) begin
      unique case (req.group)
        GRP_COPROC_ACC: mon_hit = kc[MB_COPROC_ACC] && !from_user;
        GRP_HYP_TRAP_REG: mon_hit = kc[MB_COPROC_ACC] && req.level == LVL_HYP;
        GRP_COMMS_CHAN: mon_hit = fgt_on && kc[MB_COMMS];
        GRP_PD_DBG: mon_hit = kc[MB_PD_DBG];
        GRP_DBG: mon_hit = kc[MB_DBG];
        GRP_TRACE: mon_hit = kc[MB_TRACE] && req.coproc == CP_DBG;
        default: mon_hit = 1'b0;
      endcase
    end
  end

  // ************************************************************
  // syndrome assembly
  // ************************************************************
  function automatic logic [4:0] reg_view(input logic [3:0] r);
    reg_view = (r == REG_PC) ? REG_ZR : {1'b0, r};
  endfunction : reg_view

  logic cv_bit;
  logic [3:0] code_a_val;
  logic [5:0] ec_val;
  logic [24:0] iss_val;

  always_comb begin
    cv_bit = 1'b1;
    code_a_val = CODE_A_ALWAYS;
    if (!req.from_64) begin
      if (req.mixed_len && !MIXED_CV) begin
        // condition lives in the saved state for mixed-length code
        cv_bit = 1'b0;
        code_a_val = 4'h0;
      end else if (req.conditional && !PASS_AS_UNCOND) begin
        code_a_val = req.code_a;
      end
    end
  end

  always_comb begin
    ec_val = EC_MOVE_SYS;
    iss_val = 25'h0000000;
    iss_val[ISS_CV] = cv_bit;
    iss_val[ISS_CODE_A +: 4] = code_a_val;
    iss_val[ISS_DIR] = req.is_read;
    unique case (req.kind)
      CTS_MOVE_ONE: begin
        ec_val = (req.coproc == CP_DBG) ? EC_MOVE_DBG : EC_MOVE_SYS;
        iss_val[ISS_OPC2 +: 3] = req.opc2;
        iss_val[ISS_FIRST_OPCODE_FIELD +: 3] = req.first_opcode_field[2:0];
        iss_val[ISS_CRN +: 4] = req.crn;
        iss_val[ISS_RT +: 5] = reg_view(req.rt);
        iss_val[ISS_CRM +: 4] = req.coproc_minor_reg;
      end
      CTS_MOVE_PAIR: begin
        ec_val = (req.coproc == CP_DBG) ? EC_PAIR_DBG : EC_PAIR_SYS;
        iss_val[ISS_PAIR_FIRST_OPCODE_FIELD +: 4] = req.first_opcode_field;
        iss_val[ISS_PAIR_RSV] = 1'b0;
        iss_val[ISS_RT2 +: 5] = reg_view(req.rt2);
        iss_val[ISS_RT +: 5] = reg_view(req.rt);
        iss_val[ISS_CRM +: 4] = req.coproc_minor_reg;
      end
      CTS_FLOAT_READ: begin
        // float register reads carry fixed opcode fields and read direction
        ec_val = EC_FLOAT_ID;
        iss_val[ISS_OPC2 +: 3] = 3'h0;
        iss_val[ISS_FIRST_OPCODE_FIELD +: 3] = FLOAT_FIRST_OPCODE_FIELD;
        iss_val[ISS_CRN +: 4] = req.crn;
        iss_val[ISS_RT +: 5] = reg_view(req.rt);
        iss_val[ISS_CRM +: 4] = 4'h0;
        iss_val[ISS_DIR] = 1'b1;
      end
      CTS_WIDE_LS: begin
        ec_val = EC_WIDE_LS;
        iss_val = {23'h000000, req.variant};
      end
    endcase
  end

  // ************************************************************
  // next state: register bus and capture
  // ************************************************************
  always_comb begin
    logic do_write, rd_ok, wr_ok;
    logic [31:0] rd;
    do_write = 1'b0;
    rd = 32'h00000000;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    state_next = state_reg;
    // write channels are taken in either order and held until the response
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      do_write = 1'b1;
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
    end
    if (do_write) begin
      for (int b = 0; b < 2; b++) begin
        if (state_reg.wstrb[b]) begin
          if (state_reg.aw_addr == OFS_HYP_CTRL) begin
            state_next.hyp_ctrl[8*b +: 8] = state_reg.wdata[8*b +: 8];
          end else if (state_reg.aw_addr == OFS_KMON_CTRL) begin
            state_next.kmon_ctrl[8*b +: 8] = state_reg.wdata[8*b +: 8];
          end
        end
      end
      // status registers are read-only; writes to them are refused
      wr_ok = (state_reg.aw_addr == OFS_HYP_CTRL) || (state_reg.aw_addr == OFS_KMON_CTRL);
      state_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    unique case (s_axi_araddr)
      OFS_HYP_CTRL: rd = {16'h0000, state_reg.hyp_ctrl};
      OFS_KMON_CTRL: rd = {16'h0000, state_reg.kmon_ctrl};
      OFS_SYNDROME: rd = {state_reg.ec, 1'b0, state_reg.syndrome_specific_field};
      OFS_TRAP_STAT: rd = {state_reg.trap_count, 14'h0000, state_reg.resp_level};
      default: rd_ok = 1'b0;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = rd;
      state_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    // one answer per request, one cycle later
    state_next.resp_valid = req.valid;
    state_next.resp_trap = req.valid && (kern_hit || hyp_hit || mon_hit);
    if (state_next.resp_trap) begin
      // lowest target level wins so the nearest handler sees it first
      state_next.resp_level = kern_hit ? LVL_KERNEL : (hyp_hit ? LVL_HYP : LVL_MON);
      state_next.ec = ec_val;
      state_next.syndrome_specific_field = iss_val;
      state_next.trap_count = state_reg.trap_count + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.hyp_ctrl <= HYP_CTRL_RST;
      state_reg.kmon_ctrl <= KMON_CTRL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign resp_valid = state_reg.resp_valid;
  assign resp_trap = state_reg.resp_trap;
  assign resp_level = state_reg.resp_level;
  // syndrome holds whatever the last trap left; zero from reset until the first
  assign resp_class = state_reg.ec;
  assign resp_syndrome = state_reg.syndrome_specific_field;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_trap_of(logic c);
    req.valid && c ##1 resp_trap;
  endsequence

  property p_dir_read;
    s_trap_of(req.kind == CTS_MOVE_ONE && req.is_read) |-> resp_syndrome[ISS_DIR];
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("read trap lacks direction bit");
  property p_class_sys;
    s_trap_of(req.kind == CTS_MOVE_ONE && req.coproc == CP_SYS) |-> resp_class == 6'h03;
  endproperty
  a_class_sys: assert property (p_class_sys) else $error("wrong class for cp15 move");
  property p_class_dbg;
    s_trap_of(req.kind == CTS_MOVE_ONE && req.coproc == CP_DBG) |-> resp_class == 6'h05;
  endproperty
  a_class_dbg: assert property (p_class_dbg) else $error("wrong class for cp14 move");
  property p_float_id;
    req.valid && req.kind == CTS_FLOAT_READ && req.group == GRP_ID3 && !req.from_64 &&
      req.level <= LVL_KERNEL && state_reg.hyp_ctrl[HB_ID3]
      |=> resp_trap && resp_level == LVL_HYP && resp_class == 6'h08;
  endproperty
  a_float_id: assert property (p_float_id) else $error("float ID read not routed");
  property p_user_timer;
    req.valid && req.kind == CTS_MOVE_ONE && req.group == GRP_TIMER && !req.from_64 &&
      req.level == LVL_USER && !state_reg.kmon_ctrl[KB_USER_TIMER_EN]
      |=> resp_trap && resp_level == LVL_KERNEL;
  endproperty
  a_user_timer: assert property (p_user_timer) else $error("user timer not trapped");
  property p_mon_acc;
    req.valid && req.kind == CTS_MOVE_ONE && req.group == GRP_COPROC_ACC && !req.from_64 &&
      req.level == LVL_KERNEL && state_reg.kmon_ctrl[MB_COPROC_ACC]
      |=> resp_trap && resp_level == LVL_MON;
  endproperty
  a_mon_acc: assert property (p_mon_acc) else $error("access control not to monitor");
  property p_code_a_64;
    s_trap_of(req.kind != CTS_WIDE_LS && (req.from_64 || !req.mixed_len) && !req.conditional)
      |-> resp_syndrome[ISS_CV] && resp_syndrome[ISS_CODE_A +: 4] == 4'hE;
  endproperty
  a_code_a_64: assert property (p_code_a_64) else $error("bad unconditional code");
  property p_pair_opc;
    req.valid && req.kind == CTS_MOVE_PAIR ##1 resp_trap
      |-> resp_syndrome[19:16] == $past(req.first_opcode_field) && !resp_syndrome[15];
  endproperty
  a_pair_opc: assert property (p_pair_opc) else $error("pair opcode field wrong");
  property p_reg15;
    s_trap_of(req.kind == CTS_MOVE_ONE && req.rt == 4'hF) |-> resp_syndrome[9:5] == 5'h1F;
  endproperty
  a_reg15: assert property (p_reg15) else $error("register 15 not shown as 0x1F");
  property p_wide;
    req.valid && req.kind == CTS_WIDE_LS ##1 resp_trap
      |-> resp_syndrome == {23'h000000, $past(req.variant)};
  endproperty
  a_wide: assert property (p_wide) else $error("wide access code wrong");
  property p_hold;
    !resp_trap ##1 !resp_trap |-> $stable(resp_syndrome) && $stable(resp_class);
  endproperty
  a_hold: assert property (p_hold) else $error("syndrome changed without trap");

endmodule : cts_trap_syndrome

/* cts_pipe_model.sv */
// stand-in for the core pipeline that issues trap requests
`timescale 1ns/1ns
module cts_pipe_model
  import cts_pkg::*;
(
  input wire logic aclk,
  output cts_req_t req
);
  // ************************************************************
  // request issue
  // ************************************************************
  initial req = '0;
  task send(input cts_req_t r);
    cts_req_t z;
    z = ~r;
    z.valid = 1'b0;
    r.valid = 1'b1;
    @(posedge aclk);
    req <= r;
    @(posedge aclk);
    // fields are only meaningful with valid, so show garbage afterwards
    req <= z;
  endtask : send
endmodule : cts_pipe_model

/* test_coprocessor_trap_syndrome.sv */
// self-checking bench for the trap syndrome unit
`timescale 1ns/1ns
module test_coprocessor_trap_syndrome;
  import cts_pkg::*;
  typedef struct packed {cts_req_t r; logic [15:0] hc; logic [15:0] kc; logic tr;
    logic [1:0] lv; logic [5:0] ec;} cts_row_t;
  localparam logic [5:0] WIDE_EC = 6'h0A;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, rv, rt;
  logic [1:0] bresp, rresp, lvl, ex_lv;
  logic [5:0] ecl, ex_ec;
  logic [24:0] syn, ex_is;
  logic [15:0] nt;
  cts_req_t req;
  cts_row_t rows[19];
  int bad_count = 0, checks_done = 0;
  always #5 aclk = ~aclk;
  cts_pipe_model pipe (.aclk(aclk), .req(req));
  cts_trap_syndrome #(.EC_WIDE_LS(WIDE_EC)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .req(req), .resp_valid(rv), .resp_trap(rt), .resp_level(lvl), .resp_class(ecl),
    .resp_syndrome(syn));
  // ************************************************************
  // bus, check and expectation helpers
  // ************************************************************
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one register access; w selects write, d is write data or expected read data
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] got;
    logic [1:0] rs;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (bready && bvalid) begin
        rs = bresp;
        bready <= 1'b0;
      end
      if (rready && rvalid) begin
        rs = rresp;
        got = rdata;
        rready <= 1'b0;
      end
    end while (awvalid || wvalid || bready || arvalid || rready);
    chk("resp", er, rs);
    if (!w) chk("rdata", d, got);
  endtask : acc
  function automatic cts_req_t q(cts_kind_t k, cts_group_t g, logic rd, logic [3:0] cp,
      logic [1:0] lv, logic [3:0] cd, logic [1:0] vr);
    q = '{1'b0, k, g, rd, cp, lv, 1'b0, 1'b0, cd != CODE_A_ALWAYS, cd, 4'h9, 3'h6, 4'hA, 4'h3,
      REG_PC, 4'h2, cts_variant_t'(vr)};
  endfunction : q
  function automatic logic [24:0] es(cts_req_t r);
    logic [3:0] c;
    logic [4:0] t1, t2;
    c = r.conditional ? r.code_a : CODE_A_ALWAYS;
    t1 = (r.rt == REG_PC) ? REG_ZR : {1'b0, r.rt};
    t2 = (r.rt2 == REG_PC) ? REG_ZR : {1'b0, r.rt2};
    case (r.kind)
      CTS_MOVE_ONE: es = {1'b1, c, r.opc2, r.first_opcode_field[2:0], r.crn, t1, r.coproc_minor_reg, r.is_read};
      CTS_FLOAT_READ: es = {1'b1, c, 3'h0, FLOAT_FIRST_OPCODE_FIELD, r.crn, t1, 4'h0, 1'b1};
      CTS_MOVE_PAIR: es = {1'b1, c, r.first_opcode_field, 1'b0, t2, t1, r.coproc_minor_reg, r.is_read};
      default: es = {23'h0, r.variant};
    endcase
  endfunction : es
  task end_sim();
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    end_sim();
  end
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    rows = '{
      '{q(CTS_MOVE_ONE, GRP_TIMER, 1, CP_SYS, LVL_USER, CODE_A_ALWAYS, 0), 16'h0, 16'h0, 1,
        LVL_KERNEL, EC_MOVE_SYS},
      '{q(CTS_MOVE_ONE, GRP_TIMER, 1, CP_SYS, LVL_USER, CODE_A_ALWAYS, 0), 16'h0, 16'h1, 0,
        0, 0},
      '{q(CTS_MOVE_ONE, GRP_TRACE, 0, CP_DBG, LVL_KERNEL, 4'h3, 0), 16'h0400, 16'h0, 1,
        LVL_HYP, EC_MOVE_DBG},
      '{q(CTS_FLOAT_READ, GRP_ID3, 1, CP_SYS, LVL_KERNEL, CODE_A_ALWAYS, 0), 16'h1000, 16'h0,
        1, LVL_HYP, EC_FLOAT_ID},
      '{q(CTS_MOVE_PAIR, GRP_TLB, 0, CP_SYS, LVL_KERNEL, CODE_A_ALWAYS, 0), 16'h0001, 16'h0,
        1, LVL_HYP, EC_PAIR_SYS},
      '{q(CTS_MOVE_ONE, GRP_COPROC_ACC, 1, CP_SYS, LVL_KERNEL, CODE_A_ALWAYS, 0), 16'h0,
        16'h0100, 1, LVL_MON, EC_MOVE_SYS},
      '{q(CTS_MOVE_ONE, GRP_ID0, 0, CP_DBG, LVL_KERNEL, CODE_A_ALWAYS, 0), 16'h0800, 16'h0, 0,
        0, 0},
      '{q(CTS_MOVE_ONE, GRP_ID0, 1, CP_DBG, LVL_USER, CODE_A_ALWAYS, 0), 16'h0800, 16'h0, 1,
        LVL_HYP, EC_MOVE_DBG},
      '{q(CTS_WIDE_LS, GRP_PLAIN, 0, CP_SYS, LVL_USER, CODE_A_ALWAYS, 0), 16'h0, 16'h0020, 1,
        LVL_KERNEL, WIDE_EC},
      '{q(CTS_WIDE_LS, GRP_PLAIN, 0, CP_SYS, LVL_USER, CODE_A_ALWAYS, 1), 16'h0, 16'h0020, 1,
        LVL_KERNEL, WIDE_EC},
      '{q(CTS_WIDE_LS, GRP_PLAIN, 0, CP_SYS, LVL_USER, CODE_A_ALWAYS, 2), 16'h0, 16'h0020, 1,
        LVL_KERNEL, WIDE_EC},
      '{q(CTS_MOVE_ONE, GRP_COMMS_CHAN, 1, CP_DBG, LVL_USER, CODE_A_ALWAYS, 0), 16'h0,
        16'h0008, 1, LVL_KERNEL, EC_MOVE_DBG},
      '{q(CTS_MOVE_ONE, GRP_DBG_ROM, 1, CP_DBG, LVL_KERNEL, CODE_A_ALWAYS, 0), 16'h2000,
        16'h0, 1, LVL_HYP, EC_MOVE_DBG},
      '{q(CTS_MOVE_ONE, GRP_VMEM, 1, CP_SYS, LVL_KERNEL, CODE_A_ALWAYS, 0), 16'h0010, 16'h0,
        1, LVL_HYP, EC_MOVE_SYS},
      '{q(CTS_MOVE_ONE, GRP_PD_DBG, 0, CP_DBG, LVL_USER, 4'h5, 0), 16'h0100, 16'h0, 1,
        LVL_HYP, EC_MOVE_DBG},
      '{q(CTS_MOVE_ONE, GRP_FGT_SEL, 1, CP_SYS, LVL_USER, CODE_A_ALWAYS, 0), 16'h4000,
        16'h0, 1, LVL_HYP, EC_MOVE_SYS},
      '{q(CTS_MOVE_ONE, GRP_HYP_TRAP_REG, 0, CP_SYS, LVL_HYP, CODE_A_ALWAYS, 0), 16'h0,
        16'h0100, 1, LVL_MON, EC_MOVE_SYS},
      '{q(CTS_MOVE_ONE, GRP_COMMS_CHAN, 0, CP_DBG, LVL_KERNEL, CODE_A_ALWAYS, 0), 16'h0080,
        16'h0, 1, LVL_HYP, EC_MOVE_DBG},
      '{q(CTS_MOVE_PAIR, GRP_DBG, 1, CP_DBG, LVL_USER, CODE_A_ALWAYS, 0), 16'h0, 16'h0800,
        1, LVL_MON, EC_PAIR_DBG}};
    rows[14].r.mixed_len = 1'b1;
    {ex_lv, ex_ec, ex_is, nt} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    acc(0, OFS_HYP_CTRL, 32'h0, RESP_OKAY);
    acc(0, OFS_KMON_CTRL, 32'h0, RESP_OKAY);
    acc(0, OFS_TRAP_STAT, 32'h0, RESP_OKAY);
    foreach (rows[i]) begin
      acc(1, OFS_HYP_CTRL, {16'h0, rows[i].hc}, RESP_OKAY);
      acc(1, OFS_KMON_CTRL, {16'h0, rows[i].kc}, RESP_OKAY);
      pipe.send(rows[i].r);
      #1;
      if (rows[i].tr) begin
        {ex_lv, ex_ec, ex_is} = {rows[i].lv, rows[i].ec, es(rows[i].r)};
        nt++;
      end
      chk("resp_valid", 1, rv);
      chk("resp_trap", rows[i].tr, rt);
      chk("resp_level", ex_lv, lvl);
      chk("resp_class", ex_ec, ecl);
      chk("resp_syndrome", ex_is, syn);
      @(posedge aclk);
      #1;
      chk("resp_valid", 0, rv);
    end
    // upper half of a control word is not stored, so it must read back as zero
    acc(1, OFS_HYP_CTRL, 32'hABCD1234, RESP_OKAY);
    acc(0, OFS_HYP_CTRL, 32'h00001234, RESP_OKAY);
    acc(1, OFS_SYNDROME, 32'h1, RESP_SLVERR);
    acc(0, 8'h10, 32'h0, RESP_SLVERR);
    acc(0, OFS_SYNDROME, {ex_ec, 1'b0, ex_is}, RESP_OKAY);
    acc(0, OFS_TRAP_STAT, {nt, 14'h0, ex_lv}, RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    acc(0, OFS_HYP_CTRL, 32'h0, RESP_OKAY);
    acc(0, OFS_SYNDROME, 32'h0, RESP_OKAY);
    end_sim();
  end
endmodule : test_coprocessor_trap_syndrome
